// file: kwi_pkg.sv
package kwi_pkg;

  // bus geometry
  localparam int unsigned ADDR_W   = 8;
  localparam int unsigned DATA_W   = 8;
  localparam int unsigned NUM_KEYS = 5;
  localparam int unsigned NUM_EVT  = 3;

  // register offsets
  localparam logic [7:0] OFS_STATUS_CONTROL = 8'h1a;
  localparam logic [7:0] OFS_PIN_ENABLE     = 8'h1b;
  localparam logic [7:0] OFS_EVT_STATUS     = 8'h1c;
  localparam logic [7:0] OFS_EVT_MASK       = 8'h1d;

  // keypad_status_control field positions
  localparam int unsigned BIT_PENDING = 3;
  localparam int unsigned BIT_ACK     = 2;
  localparam int unsigned BIT_MASK    = 1;
  localparam int unsigned BIT_SENSE   = 0;

  // event status bit positions
  localparam int unsigned EVT_LATCHED = 0;
  localparam int unsigned EVT_ACKED   = 1;
  localparam int unsigned EVT_REFUSED = 2;

  // values after reset
  localparam logic [4:0] RST_PIN_ENABLE = 5'h00;
  localparam logic       RST_MASK       = 1'b0;
  localparam logic       RST_SENSE      = 1'b0;
  localparam logic [2:0] RST_EVT_MASK   = 3'h0;
  localparam logic [7:0] RST_RDATA      = 8'h00;

  // synchroniser depth
  localparam int unsigned SYNC_STAGES = 2;

  // request state, gray along idle -> pending -> wait for release
  typedef enum logic [1:0] {
    KWI_IDLE    = 2'b00,
    KWI_PEND    = 2'b01,
    KWI_RELWAIT = 2'b11
  } kwi_state_t;

endpackage

// file: kwi_sync.sv
`timescale 1ns/1ns
module kwi_sync #(
  parameter int unsigned WIDTH  = 5,
  parameter int unsigned STAGES = 2
) (
  input  wire logic             clk_sys,
  input  wire logic             rstn,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  import kwi_pkg::*;

  // pins idle high through their pull-ups
  logic [WIDTH-1:0] chain_q [STAGES];
  logic [WIDTH-1:0] chain_d [STAGES];

  always_comb begin
    chain_d[0] = async_in;
    for (int i = 1; i < STAGES; i++) begin
      chain_d[i] = chain_q[i-1];
    end
  end

  genvar g;
  generate
    for (g = 0; g < STAGES; g++) begin : g_stage
      always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
          chain_q[g] <= '1;
        end else begin
          chain_q[g] <= chain_d[g];
        end
      end
    end
  endgenerate

  assign sync_out = chain_q[STAGES-1];

endmodule

// file: kwi_evt_irq.sv
`timescale 1ns/1ns
module kwi_evt_irq #(
  parameter int unsigned N = 3
) (
  input  wire logic         clk_sys,
  input  wire logic         rstn,
  input  wire logic [N-1:0] evt_set,
  input  wire logic         status_rd,
  input  wire logic         mask_wr,
  input  wire logic [N-1:0] mask_wdata,
  output logic      [N-1:0] status_q,
  output logic      [N-1:0] mask_q,
  output logic              irq_q
);
  import kwi_pkg::*;

  logic [N-1:0] status_d;
  logic [N-1:0] mask_d;
  logic         irq_d;

  // sticky bits, a new event beats the read clear
  always_comb begin
    status_d = status_rd ? evt_set : (status_q | evt_set);
    mask_d   = mask_wr ? mask_wdata : mask_q;
    irq_d    = |(status_d & mask_d);
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      status_q <= '0;
      mask_q   <= N'(RST_EVT_MASK);
      irq_q    <= 1'b0;
    end else begin
      status_q <= status_d;
      mask_q   <= mask_d;
      irq_q    <= irq_d;
    end
  end

endmodule

// file: kwi_top.sv
// What this block does
// - first fall among high enabled pins latches request
// - level mode clears after ack and release
// - vector fetch acknowledges like software
// - enabled pin gets pull-up, forced input
// - status bits seven to four read zero
// - pending flag read-only, reset clears it
// - writing ack one clears request, reads zero
// - mask blocks cpu interrupt, flag still shows
// - sensitivity one edge-and-level, zero edge-only
// - five enables gate pins, reset clears all
// - enable bits four to zero, rest zero
// - unmasked request wakes processor from wait
// - unmasked request wakes processor from stop
// - break clear allowed lets ack writes clear flag
// - break clear blocked ignores ack writes
//
// The address-and-strobe port is this design's own decision.
`timescale 1ns/1ns
module kwi_top (
  input  wire logic                             clk_sys,
  input  wire logic                             rstn,
  input  wire logic [kwi_pkg::ADDR_W-1:0]       addr,
  input  wire logic [kwi_pkg::DATA_W-1:0]       wdata,
  input  wire logic                             wr_en,
  input  wire logic                             rd_en,
  output logic      [kwi_pkg::DATA_W-1:0]       rdata,
  input  wire logic [kwi_pkg::NUM_KEYS-1:0]     keypad_irq_pins,
  input  wire logic                             vector_fetch,
  input  wire logic                             break_state,
  input  wire logic                             break_clear_enable,
  output logic      [kwi_pkg::NUM_KEYS-1:0]     pullup_en,
  output logic      [kwi_pkg::NUM_KEYS-1:0]     force_input,
  output logic                                  key_irq,
  output logic                                  wakeup,
  output logic                                  irq
);
  import kwi_pkg::*;

  // register hit decode
  function automatic logic hit(input logic [ADDR_W-1:0] a,
                               input logic [7:0]        ofs);
    hit = (a == ofs);
  endfunction

  logic [NUM_KEYS-1:0] pins_sync;
  logic [NUM_KEYS-1:0] key_pin_enables_q;
  logic [NUM_KEYS-1:0] key_pin_enables_d;
  logic                key_irq_mask_q;
  logic                key_irq_mask_d;
  logic                key_sensitivity_select_q;
  logic                key_sensitivity_select_d;
  kwi_state_t          state_q;
  kwi_state_t          state_d;
  logic                any_low_q;
  logic                any_low_d;
  logic [DATA_W-1:0]   rdata_q;
  logic [DATA_W-1:0]   rdata_d;
  logic                key_irq_q;
  logic                key_irq_d;
  logic                wakeup_q;
  logic                wakeup_d;
  logic [NUM_KEYS-1:0] pullup_q;
  logic [NUM_KEYS-1:0] pullup_d;
  logic [NUM_KEYS-1:0] force_in_q;
  logic [NUM_KEYS-1:0] force_in_d;

  logic                wr_ctl;
  logic                wr_en_reg;
  logic                ack_write;
  logic                ack_blocked;
  logic                sw_ack;
  logic                ack;
  logic                fall;
  logic                key_pending_flag;
  logic [NUM_EVT-1:0]  evt_set;
  logic [NUM_EVT-1:0]  evt_status;
  logic [NUM_EVT-1:0]  evt_mask;
  logic                evt_status_rd;
  logic                evt_mask_wr;

  kwi_sync #(
    .WIDTH  (NUM_KEYS),
    .STAGES (SYNC_STAGES)
  ) u_sync (
    .clk_sys  (clk_sys),
    .rstn     (rstn),
    .async_in (keypad_irq_pins),
    .sync_out (pins_sync)
  );

  // bus decode
  always_comb begin
    wr_ctl        = wr_en && hit(addr, OFS_STATUS_CONTROL);
    wr_en_reg     = wr_en && hit(addr, OFS_PIN_ENABLE);
    evt_mask_wr   = wr_en && hit(addr, OFS_EVT_MASK);
    evt_status_rd = rd_en && hit(addr, OFS_EVT_STATUS);
    ack_write     = wr_ctl && wdata[BIT_ACK];
    ack_blocked   = ack_write && break_state && !break_clear_enable;
    sw_ack        = ack_write && !ack_blocked;
    ack           = sw_ack || vector_fetch;
  end

  // pin level and edge detection on enabled pins only
  always_comb begin
    any_low_d = |(~pins_sync & key_pin_enables_q);
    fall      = any_low_d && !any_low_q;
  end

  // control register next values
  always_comb begin
    key_pin_enables_d        = key_pin_enables_q;
    key_irq_mask_d           = key_irq_mask_q;
    key_sensitivity_select_d = key_sensitivity_select_q;
    if (wr_en_reg) begin
      key_pin_enables_d = wdata[NUM_KEYS-1:0];
    end
    if (wr_ctl) begin
      key_irq_mask_d           = wdata[BIT_MASK];
      key_sensitivity_select_d = wdata[BIT_SENSE];
    end
  end

  // request state: a new fall beats any acknowledge
  always_comb begin
    state_d = state_q;
    case (state_q)
      KWI_IDLE: begin
        if (fall) begin
          state_d = KWI_PEND;
        end
      end
      KWI_PEND: begin
        if (fall) begin
          state_d = KWI_PEND;
        end else if (ack) begin
          if (key_sensitivity_select_q && any_low_d) begin
            state_d = KWI_RELWAIT;
          end else begin
            state_d = KWI_IDLE;
          end
        end
      end
      KWI_RELWAIT: begin
        if (!any_low_d || !key_sensitivity_select_q) begin
          state_d = KWI_IDLE;
        end
      end
      default: begin
        state_d = KWI_IDLE;
      end
    endcase
  end

  // outputs toward cpu, pads and wake logic
  always_comb begin
    key_pending_flag = (state_q != KWI_IDLE);
    key_irq_d        = (state_d != KWI_IDLE) && !key_irq_mask_d;
    wakeup_d         = key_irq_d;
    pullup_d         = key_pin_enables_d;
    force_in_d       = key_pin_enables_d;
  end

  // event sources for the summary interrupt
  always_comb begin
    evt_set              = '0;
    evt_set[EVT_LATCHED] = fall && (state_q == KWI_IDLE);
    evt_set[EVT_ACKED]   = ack && key_pending_flag;
    evt_set[EVT_REFUSED] = ack_blocked;
  end

  // read data, registered for the next cycle
  always_comb begin
    rdata_d = '0;
    if (rd_en) begin
      if (hit(addr, OFS_STATUS_CONTROL)) begin
        rdata_d[BIT_PENDING] = key_pending_flag;
        rdata_d[BIT_MASK]    = key_irq_mask_q;
        rdata_d[BIT_SENSE]   = key_sensitivity_select_q;
      end else if (hit(addr, OFS_PIN_ENABLE)) begin
        rdata_d[NUM_KEYS-1:0] = key_pin_enables_q;
      end else if (hit(addr, OFS_EVT_STATUS)) begin
        rdata_d[NUM_EVT-1:0] = evt_status;
      end else if (hit(addr, OFS_EVT_MASK)) begin
        rdata_d[NUM_EVT-1:0] = evt_mask;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      key_pin_enables_q        <= RST_PIN_ENABLE;
      key_irq_mask_q           <= RST_MASK;
      key_sensitivity_select_q <= RST_SENSE;
      state_q                  <= KWI_IDLE;
      any_low_q                <= 1'b0;
      rdata_q                  <= RST_RDATA;
      key_irq_q                <= 1'b0;
      wakeup_q                 <= 1'b0;
      pullup_q                 <= RST_PIN_ENABLE;
      force_in_q               <= RST_PIN_ENABLE;
    end else begin
      key_pin_enables_q        <= key_pin_enables_d;
      key_irq_mask_q           <= key_irq_mask_d;
      key_sensitivity_select_q <= key_sensitivity_select_d;
      state_q                  <= state_d;
      any_low_q                <= any_low_d;
      rdata_q                  <= rdata_d;
      key_irq_q                <= key_irq_d;
      wakeup_q                 <= wakeup_d;
      pullup_q                 <= pullup_d;
      force_in_q               <= force_in_d;
    end
  end

  kwi_evt_irq #(
    .N (NUM_EVT)
  ) u_evt (
    .clk_sys    (clk_sys),
    .rstn       (rstn),
    .evt_set    (evt_set),
    .status_rd  (evt_status_rd),
    .mask_wr    (evt_mask_wr),
    .mask_wdata (wdata[NUM_EVT-1:0]),
    .status_q   (evt_status),
    .mask_q     (evt_mask),
    .irq_q      (irq)
  );

  assign rdata       = rdata_q;
  assign key_irq     = key_irq_q;
  assign wakeup      = wakeup_q;
  assign pullup_en   = pullup_q;
  assign force_input = force_in_q;

endmodule

// file: kwi_top_properties.sv
`timescale 1ns/1ns
module kwi_chk
  import kwi_pkg::*;
(
  input wire logic       clk_sys,
  input wire logic       rstn,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic       wr_en,
  input wire logic       rd_en,
  input wire logic [7:0] rdata,
  input wire logic [4:0] keypad_irq_pins,
  input wire logic       vector_fetch,
  input wire logic       break_state,
  input wire logic       break_clear_enable,
  input wire logic [4:0] pullup_en,
  input wire logic [4:0] force_input,
  input wire logic       key_irq,
  input wire logic       wakeup,
  input wire logic       irq
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  wire all_hi = &(keypad_irq_pins | ~pullup_en);
  wire st_wr  = wr_en && addr == OFS_STATUS_CONTROL;

  a_pins_forced_in: assert property (pullup_en == force_input) else $error("force differs");
  a_wake_is_irq: assert property (wakeup == key_irq) else $error("wakeup differs");
  a_status_zero_bits: assert property (rd_en && addr == OFS_STATUS_CONTROL |=>
    rdata[7:4] == 4'h0 && !rdata[BIT_ACK]) else $error("status zero bits");
  a_enable_readback: assert property (rd_en && addr == OFS_PIN_ENABLE |=>
    rdata == {3'h0, pullup_en}) else $error("enable readback");
  a_enable_write: assert property (wr_en && addr == OFS_PIN_ENABLE |=>
    pullup_en == $past(wdata[4:0])) else $error("enable write");
  a_mask_blocks: assert property (st_wr && wdata[BIT_MASK] |-> ##2 !key_irq) else $error("mask");
  a_fetch_clears: assert property (all_hi [*4] ##0 vector_fetch |=> ##1 !key_irq)
    else $error("fetch did not clear");
  a_break_keeps: assert property (break_state && !break_clear_enable && st_wr && wdata[BIT_ACK]
    && !wdata[BIT_MASK] && !vector_fetch |=> (key_irq |=> key_irq)) else $error("break ack");
endmodule
bind kwi_top kwi_chk chk (.*);

// file: kwi_keys.sv
`timescale 1ns/1ns
module kwi_keys (
  input  wire logic       clk_sys,
  input  wire logic [4:0] press,
  input  wire logic [4:0] pullup_en,
  input  wire logic [4:0] drive_hi,
  output logic      [4:0] pins
);
  logic tgl_q = 1'b0;
  always_ff @(posedge clk_sys) begin
    tgl_q <= ~tgl_q;
  end
  // pressed key grounds pin; released pin pulled up, floats without pull-up
  // pins held high as outputs before enabling
  assign pins = ~press & (pullup_en | drive_hi | {5{tgl_q}});
endmodule

// file: kwi_top_test.sv
`timescale 1ns/1ns
module kwi_top_test;
  import kwi_pkg::*;
  logic        clk_sys, rstn, wr_en, rd_en, vfetch, brk, bce, key_irq, wakeup, irq;
  logic [7:0]  addr, wdata, rdata, got;
  logic [4:0]  press, pins, pullup_en, force_input, drive_hi;
  int          errors = 0, checked = 0, cyc = 0;
  logic [23:0] rows [8] = '{24'h1aff03, 24'h1a0000, 24'h1bff1f, 24'h1b0a0a, 24'h1b0000, 24'h1d0707,
                            24'h1d0101, 24'h33ff00};
  kwi_top dut (.clk_sys(clk_sys), .rstn(rstn), .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en),
    .rdata(rdata), .keypad_irq_pins(pins), .vector_fetch(vfetch), .break_state(brk),
    .break_clear_enable(bce), .pullup_en(pullup_en), .force_input(force_input), .key_irq(key_irq),
    .wakeup(wakeup), .irq(irq));
  kwi_keys keys (.clk_sys(clk_sys), .press(press), .pullup_en(pullup_en), .drive_hi(drive_hi), .pins(pins));
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      errors++;
      report_and_stop();
    end
  end
  task automatic report_and_stop();
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    addr  <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk_sys);
    wr_en <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic rd(input logic [7:0] a);
    addr  <= a;
    rd_en <= 1'b1;
    @(posedge clk_sys);
    rd_en <= 1'b0;
    #1 got = rdata;
    @(posedge clk_sys);
  endtask
  // mask, enable, settle, ack, unmask
  task automatic setup(input logic [4:0] en, input logic sense);
    wr(OFS_STATUS_CONTROL, {6'h0, 1'b1, sense});
    wr(OFS_PIN_ENABLE, {3'h0, en});
    settle(4);
    wr(OFS_STATUS_CONTROL, {5'h0, 2'b11, sense});
    wr(OFS_STATUS_CONTROL, {7'h0, sense});
  endtask
  function automatic logic [7:0] flags();
    return {5'h0, irq, wakeup, key_irq};
  endfunction
  initial begin
    {rstn, wr_en, rd_en, vfetch, brk, bce} = '0;
    addr  = 8'h00;
    wdata = 8'h00;
    press = 5'h00;
    drive_hi = 5'h00;
    repeat (2) @(posedge clk_sys);
    rstn <= 1'b1;
    @(posedge clk_sys);
    rd(OFS_STATUS_CONTROL);
    chk(got, 8'h00);
    rd(OFS_PIN_ENABLE);
    chk(got, 8'h00);
    for (int i = 0; i < 8; i++) begin
      wr(rows[i][23:16], rows[i][15:8]);
      rd(rows[i][23:16]);
      chk(got, rows[i][7:0]);
    end
    setup(5'h03, 1'b0);
    rd(OFS_EVT_STATUS);
    press <= 5'h01;
    settle(6);
    chk(flags(), 8'h07);
    rd(OFS_EVT_STATUS);
    chk(got, 8'h01);
    rd(OFS_STATUS_CONTROL);
    chk(got, 8'h08);
    wr(OFS_STATUS_CONTROL, 8'h02);
    rd(OFS_STATUS_CONTROL);
    chk({got, flags()}, 16'h0a00);
    wr(OFS_STATUS_CONTROL, 8'h04);
    press <= 5'h03;
    settle(6);
    chk(flags(), 8'h00);
    press <= 5'h00;
    settle(4);
    press <= 5'h01;
    settle(6);
    chk(flags(), 8'h07);
    press <= 5'h00;
    settle(5);
    vfetch <= 1'b1;
    @(posedge clk_sys);
    vfetch <= 1'b0;
    settle(2);
    chk(flags(), 8'h04);
    setup(5'h04, 1'b1);
    press <= 5'h04;
    settle(6);
    wr(OFS_STATUS_CONTROL, 8'h05);
    settle(3);
    chk(flags(), 8'h07);
    press <= 5'h00;
    settle(6);
    chk(flags(), 8'h04);
    wr(OFS_STATUS_CONTROL, 8'h00);
    press <= 5'h04;
    settle(6);
    brk <= 1'b1;
    wr(OFS_STATUS_CONTROL, 8'h04);
    settle(3);
    chk(flags(), 8'h07);
    bce <= 1'b1;
    wr(OFS_STATUS_CONTROL, 8'h04);
    brk <= 1'b0;
    settle(3);
    chk(flags(), 8'h04);
    drive_hi <= 5'h10;
    settle(3);
    wr(OFS_PIN_ENABLE, 8'h10);
    settle(4);
    rd(OFS_STATUS_CONTROL);
    chk(got, 8'h00);
    report_and_stop();
  end
endmodule
